// ===== pwm_diag_status_consts.svh
`ifndef PWM_DIAG_STATUS_CONSTS_SVH
`define PWM_DIAG_STATUS_CONSTS_SVH

// Register offsets
`define ADDR_PWM_MAP 8'h09
`define ADDR_SOURCE_SELECT 8'h0A
`define ADDR_GEN_DUTY 8'h0B
`define ADDR_LED_DUTY 8'h0C
`define ADDR_OFF_DIAG_EN 8'h0D
`define ADDR_ON_OL_EN 8'h0E
`define ADDR_OVC_CLEAR 8'h0F
`define ADDR_STATUS_ZERO 8'h10
`define ADDR_STATUS_ONE 8'h11
`define ADDR_OVC_FAULTS 8'h12
`define ADDR_OFF_OL_FAULTS 8'h13

// Reset values
`define CFG_RESET 8'h00
`define FLAG_RESET 8'h00

// Status register zero fields
`define S0_OFF_ERR 0
`define S0_ON_ERR 1
`define S0_PAR_ZERO 2
`define S0_PAR_ONE 3
`define S0_IDLE 4
`define S0_DISABLE 6

// Status register one fields
`define S1_MODE_LSB 0
`define S1_BATT_LOW 2
`define S1_IO_LOW 3
`define S1_POR 4

// Timing: slowest PWM rate in tenths of Hz, clock in Hz, steps per period
`define CLK_HZ 20000000
`define PWM_BASE_FRQ_DHZ 1225
`define PWM_STEPS 255
`define PWM_MAX_STEP 8'hFE
`define PWM_BASE_PRESCALE (`CLK_HZ * 10 / (`PWM_BASE_FRQ_DHZ * `PWM_STEPS))

`endif

// ===== pwm_diag_status_pkg.sv
package pwm_diag_status_pkg;

	// Register access request from the serial frame decoder
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	// Inputs arriving from outside the clock domain
	typedef struct packed {
		logic ext_reset;
		logic logic_low;
		logic disable_pin;
		logic idle_pin;
		logic parallel_input_one;
		logic parallel_input_zero;
		logic io_supply_low;
		logic battery_low;
		logic por_detect;
		logic [7:0] overcurrent;
		logic [7:0] openload;
	} async_in_s;

	typedef logic [7:0] chan_t;

endpackage

// ===== pwm_duty_gen.sv
`include "pwm_diag_status_consts.svh"

module pwm_duty_gen (
	input wire logic clock_i,
	input wire logic srst_i,
	input wire logic [7:0] duty_i,
	input wire logic [1:0] divider_i,
	output logic pwm_o
);
	localparam logic [9:0] BASE = 10'(`PWM_BASE_PRESCALE);

	logic [9:0] presc_ff;
	logic [7:0] step_ff;
	logic pwm_ff;
	logic [9:0] reload;

	// Each divider code halves the step time, doubling the PWM rate
	assign reload = (BASE >> divider_i) - 10'h001;

	// Step prescaler; a divider change takes effect at the next reload
	always_ff @(posedge clock_i) begin
		if (srst_i) presc_ff <= 10'h000;
		else if (presc_ff == 10'h000) presc_ff <= reload;
		else presc_ff <= presc_ff - 10'h001;
	end

	// 255 steps per period so full scale is exactly always on
	always_ff @(posedge clock_i) begin
		if (srst_i) step_ff <= 8'h00;
		else if (presc_ff == 10'h000) step_ff <= (step_ff == `PWM_MAX_STEP) ? 8'h00 : step_ff + 8'h01;
	end

	// Zero is off, all ones is on, linear in between
	always_ff @(posedge clock_i) begin
		if (srst_i) pwm_ff <= 1'b0;
		else pwm_ff <= (duty_i == 8'hFF) | (step_ff < duty_i);
	end

	assign pwm_o = pwm_ff;
endmodule

// ===== pwm_diag_status_regs.sv
`include "pwm_diag_status_consts.svh"

// Contract
// - Select bit zero routes general generator, one routes LED generator.
// - General duty: zero off, all ones on, linear steps between.
// - LED duty uses the same encoding as general duty.
// - Off-state diagnosis runs on a channel only while enabled.
// - On-state open-load diagnosis runs on a channel only while enabled.
// - Write-one to clear register clears overcurrent flags; zero leaves them.
// - Overcurrent or overtemperature sets and holds the channel fault bit.
// - Off-state open load sets and holds the channel fault bit.
// - Status zero bit 1 latches any-channel overcurrent.
// - Status zero bit 0 latches any-channel off-state diagnosis failure.
// - Status zero echoes inputs at bits 2, 3, 4 and 6.
// - Status one bit 4 latches detected power-on condition.
// - Status one latches io supply low bit 3, battery low bit 2.
// - Status one bits 1:0 report operating mode, read only.
// - Config resets on four sources; flags reset only on power-on.
// - Bit n of every channel register is channel n.
// - Channel takes generator output only when its mapping bit is one.
// - Divider code selects 122.5, 245.1, 490.2 or 980.4 Hz.
module pwm_diag_status_regs
	import pwm_diag_status_pkg::*;
(
	input wire logic clock_i,
	input wire logic srst_i,
	input wire reg_req_s reg_req_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o,
	input wire logic soft_reset_i,
	input wire logic external_reset_pin_n_i,
	input wire logic logic_supply_low_i,
	input wire logic parallel_input_zero_i,
	input wire logic parallel_input_one_i,
	input wire logic idle_pin_i,
	input wire logic disable_pin_i,
	input wire logic disable_pin_cfg_i,
	input wire logic io_supply_low_i,
	input wire logic battery_low_i,
	input wire logic por_detect_i,
	input wire logic [7:0] overcurrent_det_i,
	input wire logic [7:0] openload_det_i,
	input wire logic [7:0] driver_on_i,
	input wire logic [1:0] mode_i,
	input wire logic [1:0] general_divider_i,
	input wire logic [1:0] led_divider_i,
	output logic [7:0] channel_pwm_o,
	output logic [7:0] off_diag_run_o,
	output logic [7:0] on_openload_run_o
);
	async_in_s raw;
	async_in_s sync1_ff;
	async_in_s sync2_ff;
	async_in_s sync3_ff;
	async_in_s pin_ff;
	logic cfg_rst;
	logic wr_hit;
	logic rd_hit;
	chan_t pwm_map_ff;
	chan_t source_select_ff;
	logic [7:0] general_duty_ff;
	logic [7:0] led_duty_ff;
	chan_t off_diag_enable_ff;
	chan_t on_openload_enable_ff;
	chan_t overcurrent_faults_ff;
	chan_t off_openload_faults_ff;
	logic on_err_ff;
	logic off_err_ff;
	logic por_flag_ff;
	logic io_low_ff;
	logic batt_low_ff;
	chan_t channel_pwm_ff;
	chan_t off_diag_run_ff;
	chan_t on_openload_run_ff;
	logic [7:0] rdata_ff;
	logic rvalid_ff;
	logic general_wave;
	logic led_wave;
	chan_t ovc_now;
	chan_t opl_now;
	chan_t ovc_clear;
	logic rd_s0;
	logic rd_s1;
	logic rd_opl;
	logic [7:0] nxt_rdata;
	logic [7:0] status_zero;
	logic [7:0] status_one;

	// Reset pin is inverted before the crossing so every stage resets to zero
	assign raw = '{ext_reset: ~external_reset_pin_n_i, logic_low: logic_supply_low_i,
		disable_pin: disable_pin_i, idle_pin: idle_pin_i,
		parallel_input_one: parallel_input_one_i, parallel_input_zero: parallel_input_zero_i,
		io_supply_low: io_supply_low_i, battery_low: battery_low_i,
		por_detect: por_detect_i, overcurrent: overcurrent_det_i, openload: openload_det_i};

	// Three-stage crossing; the first stage feeds only the second
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
		end else begin
			sync1_ff <= raw;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
		end
	end

	// A bit changes only once the second and third stages agree
	always_ff @(posedge clock_i) begin
		if (srst_i) pin_ff <= '0;
		else pin_ff <= (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (pin_ff & (sync2_ff ^ sync3_ff));
	end

	// Any of the four sources returns configuration to defaults
	assign cfg_rst = srst_i | pin_ff.ext_reset | soft_reset_i | pin_ff.logic_low;
	assign wr_hit = reg_req_i.wr;
	assign rd_hit = reg_req_i.rd;

	// Configuration registers; writes to read-only offsets fall through
	always_ff @(posedge clock_i) begin
		if (cfg_rst) begin
			pwm_map_ff <= `CFG_RESET;
			source_select_ff <= `CFG_RESET;
			general_duty_ff <= `CFG_RESET;
			led_duty_ff <= `CFG_RESET;
			off_diag_enable_ff <= `CFG_RESET;
			on_openload_enable_ff <= `CFG_RESET;
		end else if (wr_hit) begin
			case (reg_req_i.addr)
				`ADDR_PWM_MAP: pwm_map_ff <= reg_req_i.wdata;
				`ADDR_SOURCE_SELECT: source_select_ff <= reg_req_i.wdata;
				`ADDR_GEN_DUTY: general_duty_ff <= reg_req_i.wdata;
				`ADDR_LED_DUTY: led_duty_ff <= reg_req_i.wdata;
				`ADDR_OFF_DIAG_EN: off_diag_enable_ff <= reg_req_i.wdata;
				`ADDR_ON_OL_EN: on_openload_enable_ff <= reg_req_i.wdata;
				default: ;
			endcase
		end
	end

	// Two generators, rate per divider code
	pwm_duty_gen u_general_generator (
		.clock_i(clock_i),
		.srst_i(cfg_rst),
		.duty_i(general_duty_ff),
		.divider_i(general_divider_i),
		.pwm_o(general_wave)
	);

	pwm_duty_gen u_led_generator (
		.clock_i(clock_i),
		.srst_i(cfg_rst),
		.duty_i(led_duty_ff),
		.divider_i(led_divider_i),
		.pwm_o(led_wave)
	);

	// Per-channel generator choice, gated by the mapping bit; bit n is channel n
	always_ff @(posedge clock_i) begin
		if (cfg_rst) channel_pwm_ff <= 8'h00;
		else channel_pwm_ff <= pwm_map_ff &
			((source_select_ff & {8{led_wave}}) | (~source_select_ff & {8{general_wave}}));
	end

	// Diagnosis requests follow the driver state and the enables
	always_ff @(posedge clock_i) begin
		if (cfg_rst) begin
			off_diag_run_ff <= 8'h00;
			on_openload_run_ff <= 8'h00;
		end else begin
			off_diag_run_ff <= off_diag_enable_ff & ~driver_on_i;
			on_openload_run_ff <= on_openload_enable_ff & driver_on_i;
		end
	end

	// Off-state open load only counts where off diagnosis is actually running
	assign ovc_now = pin_ff.overcurrent;
	assign opl_now = pin_ff.openload & off_diag_run_ff;
	assign ovc_clear = (wr_hit && reg_req_i.addr == `ADDR_OVC_CLEAR) ? reg_req_i.wdata : 8'h00;
	assign rd_s0 = rd_hit && reg_req_i.addr == `ADDR_STATUS_ZERO;
	assign rd_s1 = rd_hit && reg_req_i.addr == `ADDR_STATUS_ONE;
	assign rd_opl = rd_hit && reg_req_i.addr == `ADDR_OFF_OL_FAULTS;

	// Overcurrent faults: write-one clear, a new event in the same cycle wins
	always_ff @(posedge clock_i) begin
		if (srst_i) overcurrent_faults_ff <= `FLAG_RESET;
		else overcurrent_faults_ff <= (overcurrent_faults_ff & ~ovc_clear) | ovc_now;
	end

	// Off-state open-load faults clear on read unless still present
	always_ff @(posedge clock_i) begin
		if (srst_i) off_openload_faults_ff <= `FLAG_RESET;
		else if (rd_opl) off_openload_faults_ff <= opl_now;
		else off_openload_faults_ff <= off_openload_faults_ff | opl_now;
	end

	// Summary flags in status zero
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			on_err_ff <= 1'b0;
			off_err_ff <= 1'b0;
		end else if (rd_s0) begin
			on_err_ff <= |ovc_now;
			off_err_ff <= |opl_now;
		end else begin
			on_err_ff <= on_err_ff | (|ovc_now);
			off_err_ff <= off_err_ff | (|opl_now);
		end
	end

	// Supply and power-on flags in status one
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			por_flag_ff <= 1'b0;
			io_low_ff <= 1'b0;
			batt_low_ff <= 1'b0;
		end else if (rd_s1) begin
			por_flag_ff <= pin_ff.por_detect;
			io_low_ff <= pin_ff.io_supply_low;
			batt_low_ff <= pin_ff.battery_low;
		end else begin
			por_flag_ff <= por_flag_ff | pin_ff.por_detect;
			io_low_ff <= io_low_ff | pin_ff.io_supply_low;
			batt_low_ff <= batt_low_ff | pin_ff.battery_low;
		end
	end

	// Status words; unused positions are hard zero
	always_comb begin
		status_zero = 8'h00;
		status_zero[`S0_OFF_ERR] = off_err_ff;
		status_zero[`S0_ON_ERR] = on_err_ff;
		status_zero[`S0_PAR_ZERO] = pin_ff.parallel_input_zero;
		status_zero[`S0_PAR_ONE] = pin_ff.parallel_input_one;
		status_zero[`S0_IDLE] = pin_ff.idle_pin;
		status_zero[`S0_DISABLE] = pin_ff.disable_pin & disable_pin_cfg_i;
		status_one = 8'h00;
		status_one[`S1_MODE_LSB +: 2] = mode_i;
		status_one[`S1_BATT_LOW] = batt_low_ff;
		status_one[`S1_IO_LOW] = io_low_ff;
		status_one[`S1_POR] = por_flag_ff;
	end

	// Read mux; write-only and unmapped offsets return zero
	always_comb begin
		nxt_rdata = 8'h00;
		case (reg_req_i.addr)
			`ADDR_PWM_MAP: nxt_rdata = pwm_map_ff;
			`ADDR_SOURCE_SELECT: nxt_rdata = source_select_ff;
			`ADDR_GEN_DUTY: nxt_rdata = general_duty_ff;
			`ADDR_LED_DUTY: nxt_rdata = led_duty_ff;
			`ADDR_OFF_DIAG_EN: nxt_rdata = off_diag_enable_ff;
			`ADDR_ON_OL_EN: nxt_rdata = on_openload_enable_ff;
			`ADDR_STATUS_ZERO: nxt_rdata = status_zero;
			`ADDR_STATUS_ONE: nxt_rdata = status_one;
			`ADDR_OVC_FAULTS: nxt_rdata = overcurrent_faults_ff;
			`ADDR_OFF_OL_FAULTS: nxt_rdata = off_openload_faults_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data is captured before the clear-on-read takes effect
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= rd_hit;
			if (rd_hit) rdata_ff <= nxt_rdata;
		end
	end

	assign rdata_o = rdata_ff;
	assign rvalid_o = rvalid_ff;
	assign channel_pwm_o = channel_pwm_ff;
	assign off_diag_run_o = off_diag_run_ff;
	assign on_openload_run_o = on_openload_run_ff;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);

	sequence s_clear_write;
		wr_hit && reg_req_i.addr == `ADDR_OVC_CLEAR;
	endsequence

	sequence s_gen_zero;
		general_duty_ff == 8'h00 ##1 general_duty_ff == 8'h00;
	endsequence

	sequence s_led_full;
		led_duty_ff == 8'hFF ##1 led_duty_ff == 8'hFF;
	endsequence

	property p_select;
		!cfg_rst ##1 !cfg_rst |-> channel_pwm_o == ($past(pwm_map_ff) &
			(($past(source_select_ff) & {8{$past(led_wave)}}) |
			(~$past(source_select_ff) & {8{$past(general_wave)}})));
	endproperty
	a_select: assert property (p_select) else $error("channel generator routing wrong");

	property p_gen_zero;
		s_gen_zero |-> !general_wave;
	endproperty
	a_gen_zero: assert property (p_gen_zero) else $error("general generator on at zero duty");

	property p_led_full;
		(!cfg_rst)[*2] ##0 s_led_full |-> led_wave;
	endproperty
	a_led_full: assert property (p_led_full) else $error("led generator off at full duty");

	property p_off_diag;
		(off_diag_run_o & ~$past(off_diag_enable_ff)) == 8'h00;
	endproperty
	a_off_diag: assert property (p_off_diag) else $error("off diagnosis without enable");

	property p_on_ol;
		(on_openload_run_o & ~$past(on_openload_enable_ff)) == 8'h00;
	endproperty
	a_on_ol: assert property (p_on_ol) else $error("on open-load diagnosis without enable");

	property p_clear;
		s_clear_write |=> (overcurrent_faults_ff & $past(reg_req_i.wdata) & ~$past(ovc_now)) == 8'h00;
	endproperty
	a_clear: assert property (p_clear) else $error("overcurrent flag not cleared");

	property p_ovc_hold;
		ovc_now != 8'h00 |=> (~overcurrent_faults_ff & $past(ovc_now)) == 8'h00 ##1
			(~overcurrent_faults_ff & $past(ovc_now, 2) & ~$past(ovc_clear)) == 8'h00;
	endproperty
	a_ovc_hold: assert property (p_ovc_hold) else $error("overcurrent fault not held");

	property p_opl_set;
		opl_now != 8'h00 |=> (~off_openload_faults_ff & $past(opl_now)) == 8'h00;
	endproperty
	a_opl_set: assert property (p_opl_set) else $error("open-load fault not latched");

	property p_summary;
		|ovc_now |=> on_err_ff ##1 (on_err_ff || $past(rd_s0));
	endproperty
	a_summary: assert property (p_summary) else $error("overcurrent summary not latched");

	property p_mode_read;
		rd_s1 |=> rvalid_o && rdata_o[1:0] == $past(mode_i) && rdata_o[7:5] == 3'h0;
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode readback wrong");

	property p_cfg_reset;
		pin_ff.ext_reset |=> source_select_ff == 8'h00 && general_duty_ff == 8'h00 &&
			pwm_map_ff == 8'h00;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("config survived reset source");

	property p_unused;
		rd_s0 |=> rdata_o[7] == 1'b0 && rdata_o[5] == 1'b0;
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bit set");
endmodule

// ===== host_model.sv
// Host side of the register port: one byte per access, strobes one cycle wide
module host_model
	import pwm_diag_status_pkg::*;
(
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	input wire logic rvalid_i,
	output reg_req_s req_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial req_o = '0;

	// Write strobe taken on the next edge; the port gives no answer to writes
	task automatic write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock_i);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clock_i);
		req_o <= '0;
	endtask

	// Read data is only trusted when rvalid is up, otherwise unknown is returned
	task automatic read(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock_i);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clock_i);
		req_o <= '0;
		#1;
		data = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
	endtask
endmodule

// ===== pwm_diag_status_regs_bench.sv
module pwm_diag_status_regs_bench
	import pwm_diag_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock_i = 1'b0;
	logic srst_i = 1'b1;
	reg_req_s req;
	logic [7:0] rdata;
	logic rvalid;
	logic soft_rst = 1'b0;
	logic ext_rst_n = 1'b1;
	logic logic_low = 1'b0;
	logic par_in_zero = 1'b0;
	logic par_in_one = 1'b0;
	logic idle_pin = 1'b0;
	logic disable_pin = 1'b0;
	logic disable_cfg = 1'b0;
	logic io_low = 1'b0;
	logic batt_low = 1'b0;
	logic por = 1'b0;
	logic [7:0] ovc = 8'h00;
	logic [7:0] opl = 8'h00;
	logic [7:0] drv_on = 8'h00;
	logic [1:0] mode = 2'b00;
	logic [1:0] gen_div = 2'b11;
	logic [1:0] led_div = 2'b10;
	logic [7:0] pwm;
	logic [7:0] off_run;
	logic [7:0] on_run;
	int failures = 0;
	int comparisons = 0;
	int gen_hi;
	int gen_per;
	int led_hi;
	// Periods in clocks at 50 ns: code 11 is 980.4 Hz, code 10 is 490.2 Hz
	localparam int GEN_PERIOD = 20400;
	localparam int LED_PERIOD = 40800;

	// 20 MHz clock
	always #25 clock_i = ~clock_i;

	host_model u_host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));

	pwm_diag_status_regs u_dut (
		.clock_i(clock_i), .srst_i(srst_i), .reg_req_i(req), .rdata_o(rdata),
		.rvalid_o(rvalid), .soft_reset_i(soft_rst), .external_reset_pin_n_i(ext_rst_n),
		.logic_supply_low_i(logic_low), .parallel_input_zero_i(par_in_zero),
		.parallel_input_one_i(par_in_one), .idle_pin_i(idle_pin), .disable_pin_i(disable_pin),
		.disable_pin_cfg_i(disable_cfg), .io_supply_low_i(io_low), .battery_low_i(batt_low),
		.por_detect_i(por), .overcurrent_det_i(ovc), .openload_det_i(opl),
		.driver_on_i(drv_on), .mode_i(mode), .general_divider_i(gen_div),
		.led_divider_i(led_div), .channel_pwm_o(pwm), .off_diag_run_o(off_run),
		.on_openload_run_o(on_run)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		comparisons++;
		if (seen !== want) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
		logic [7:0] d;
		u_host.read(a, d);
		check($sformatf("reg %h", a), 32'(d), 32'(want));
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock_i);
	endtask

	// Width of one full high pulse on a channel; a pulse already running is skipped
	task automatic high_time(input int b, output int n);
		n = 0;
		while (pwm[b] === 1'b1) @(posedge clock_i);
		while (pwm[b] !== 1'b1) @(posedge clock_i);
		while (pwm[b] === 1'b1) begin
			n++;
			@(posedge clock_i);
		end
	endtask

	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: register tests are short, the rate check needs about one slow period
	initial begin
		#(50 * 60000);
		failures++;
		results();
	end

	initial begin
		idle(4);
		srst_i <= 1'b0;
		// Every register starts cleared; unmapped space reads zero
		for (int i = 9; i <= 19; i++) rd_chk(8'(i), 8'h00);
		rd_chk(8'h20, 8'h00);
		for (int i = 0; i < 5; i++) u_host.write(8'h0A + 8'(i), 8'hA1 + 8'(i));
		for (int i = 0; i < 5; i++) rd_chk(8'h0A + 8'(i), 8'hA1 + 8'(i));
		// Clear register is write only; fault register ignores writes
		u_host.write(8'h0F, 8'hFF);
		rd_chk(8'h0F, 8'h00);
		u_host.write(8'h12, 8'hFF);
		rd_chk(8'h12, 8'h00);
		// Channel 0 on general, channel 1 on LED, the rest unmapped
		u_host.write(8'h09, 8'h03);
		u_host.write(8'h0A, 8'h02);
		u_host.write(8'h0B, 8'hFF);
		u_host.write(8'h0C, 8'h00);
		idle(6);
		check("pwm", 32'(pwm), 32'h01);
		u_host.write(8'h0B, 8'h00);
		u_host.write(8'h0C, 8'hFF);
		idle(6);
		check("pwm", 32'(pwm), 32'h02);
		// Diagnosis enables gated by driver state
		u_host.write(8'h0D, 8'h0F);
		u_host.write(8'h0E, 8'hF0);
		@(posedge clock_i) drv_on <= 8'h35;
		idle(3);
		check("off run", 32'(off_run), 32'h0A);
		check("on run", 32'(on_run), 32'h30);
		// Open load on an enabled off channel and on a disabled channel whose driver is on
		@(posedge clock_i) opl <= 8'h12;
		idle(8);
		@(posedge clock_i) opl <= 8'h00;
		idle(8);
		rd_chk(8'h13, 8'h02);
		rd_chk(8'h10, 8'h01);
		rd_chk(8'h13, 8'h00);
		rd_chk(8'h10, 8'h00);
		// Overcurrent on channel 7 latches until cleared by write
		@(posedge clock_i) ovc <= 8'h80;
		idle(8);
		@(posedge clock_i) ovc <= 8'h00;
		idle(8);
		rd_chk(8'h10, 8'h02);
		rd_chk(8'h12, 8'h80);
		// Soft, external pin and logic supply low config resets, while fault flags must survive
		for (int s = 0; s < 3; s++) begin
			u_host.write(8'h0A, 8'hA5);
			@(posedge clock_i);
			soft_rst <= (s == 0);
			ext_rst_n <= (s != 1);
			logic_low <= (s == 2);
			idle(8);
			soft_rst <= 1'b0;
			ext_rst_n <= 1'b1;
			logic_low <= 1'b0;
			idle(8);
			rd_chk(8'h0A, 8'h00);
		end
		rd_chk(8'h12, 8'h80);
		u_host.write(8'h0F, 8'h7F);
		rd_chk(8'h12, 8'h80);
		u_host.write(8'h0F, 8'h80);
		rd_chk(8'h12, 8'h00);
		// Pin echoes, mode and supply flags
		@(posedge clock_i);
		par_in_zero <= 1'b1;
		idle_pin <= 1'b1;
		disable_pin <= 1'b1;
		disable_cfg <= 1'b1;
		mode <= 2'b10;
		batt_low <= 1'b1;
		por <= 1'b1;
		idle(8);
		batt_low <= 1'b0;
		por <= 1'b0;
		idle(8);
		rd_chk(8'h10, 8'h54);
		rd_chk(8'h11, 8'h16);
		rd_chk(8'h11, 8'h02);
		@(posedge clock_i);
		par_in_zero <= 1'b0;
		par_in_one <= 1'b1;
		disable_cfg <= 1'b0;
		mode <= 2'b01;
		io_low <= 1'b1;
		idle(8);
		io_low <= 1'b0;
		idle(8);
		rd_chk(8'h10, 8'h18);
		rd_chk(8'h11, 8'h09);
		// Rates: a duty of one lasts exactly one step, 255 steps make a period
		@(posedge clock_i) mode <= 2'b11;
		u_host.write(8'h09, 8'h03);
		u_host.write(8'h0A, 8'h02);
		u_host.write(8'h0B, 8'h01);
		u_host.write(8'h0C, 8'h01);
		rd_chk(8'h11, 8'h03);
		// Both channels measured together so the slow LED rate costs no extra time
		fork
			begin
				high_time(0, gen_hi);
				gen_per = gen_hi;
				while (pwm[0] !== 1'b1) begin
					gen_per++;
					@(posedge clock_i);
				end
			end
			high_time(1, led_hi);
		join
		check("general step", gen_hi, GEN_PERIOD / 255);
		check("general period", gen_per, GEN_PERIOD);
		check("led step", led_hi, LED_PERIOD / 255);
		results();
	end
endmodule
